/* File: design/scr_pkg.sv */
package scr_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [4:0] OFS_OPTION = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK   = 5'h08;
    localparam logic [4:0] OFS_CAUSE  = 5'h0C;
    localparam logic [4:0] OFS_STATE  = 5'h10;

    // Option word two field positions
    localparam int OPT_SRC_LO   = 0;
    localparam int OPT_SRC_HI   = 1;
    localparam int OPT_PIN_CLK  = 2;
    localparam int OPT_SHORT_SD = 3;
    localparam int OPT_W        = 4;
    localparam logic [3:0] OPTION_RESET = 4'h0;

    // Event status and mask field positions
    localparam int EV_POR_DONE  = 0;
    localparam int EV_STOP_DONE = 1;
    localparam int EV_WAIT_IN   = 2;
    localparam int EV_W         = 3;
    localparam logic [2:0] EV_RESET = 3'h0;

    // Reset cause field positions
    localparam int RC_POR   = 0;
    localparam int RC_PIN   = 1;
    localparam int RC_WDOG  = 2;
    localparam int RC_LVI   = 3;
    localparam int RC_ILLOP = 4;
    localparam int RC_ILLAD = 5;
    localparam int RC_W     = 6;

    // Clock source codes
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_RC       = 2'b10,
        SRC_CRYSTAL  = 2'b11
    } scr_src_type;

    // Timing in quad-rate clock cycles
    localparam int POR_TIMEOUT_CYCLES = 4096;
    localparam int STOP_LONG_CYCLES   = 4096;
    localparam int STOP_SHORT_CYCLES  = 32;
    localparam int SYS_CNT_W          = 13;

    // Reset vectors
    localparam logic [15:0] VECTOR_USER    = 16'hFFFE;
    localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_POR_WAIT   = 3'b000,
        ST_RUN        = 3'b001,
        ST_WAIT       = 3'b010,
        ST_STOP       = 3'b011,
        ST_STOP_DELAY = 3'b100
    } scr_state_type;

endpackage : scr_pkg

/* File: design/scr_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module scr_sync #(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : scr_sync

`default_nettype wire

/* File: design/scr_top.sv */
// Overview of operation
// - Oscillator clocks keep running during break
// - Two option bits select one of four sources
// - Pin outputs quad clock for internal/RC when enabled
// - Bus clock is quad clock divided by four
// - After power-on hold clocks for 4096 cycles
// - Stop exit waits 4096 or 32 cycles
// - Wait stops CPU clocks, peripherals keep running
// - Six reset sources drive one internal reset
// - Internal reset returns option, mask and status registers to defaults
// - System counter cleared except by pin reset
// - Each reset source sets its own cause bit
// - Stop disables oscillator and derived clocks
// - Wait leaves oscillator and all clocks but the CPU clock running
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module scr_top
    import scr_pkg::*;
#(
    parameter int POR_CYCLES = POR_TIMEOUT_CYCLES,
    parameter int STOP_LONG  = STOP_LONG_CYCLES,
    parameter int STOP_SHORT = STOP_SHORT_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [4:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [4:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        STOP_REQ,
    input  wire logic        WAIT_REQ,
    input  wire logic        WAKE_EVENT,
    input  wire logic        BREAK_STATE,
    input  wire logic        MONITOR_MODE,
    input  wire logic        RESET_PIN_N,
    input  wire logic        WATCHDOG_RESET,
    input  wire logic        LOW_VOLTAGE_INHIBIT,
    input  wire logic        ILLEGAL_OPCODE,
    input  wire logic        ILLEGAL_ADDRESS,
    input  wire logic        PORT_A_LINE_FOUR_OUT,
    input  wire logic        PORT_A_LINE_FOUR_OE,
    input  wire logic        SECOND_OSCILLATOR_PIN_IN,
    output logic             SECOND_OSCILLATOR_PIN_OUT,
    output logic             SECOND_OSCILLATOR_PIN_OE,
    output logic             PORT_A_LINE_FOUR_IN,
    output logic             PORT_A_LINE_FOUR_FEATURES_EN,
    output logic [3:0]       CLOCK_SOURCE_ENABLE,
    output logic             OSC_RUNNING,
    output logic             DOUBLE_RATE_CLOCK_EN,
    output logic             BUS_CLOCK_EN,
    output logic             CPU_CLOCK_EN,
    output logic             PERIPH_CLOCK_EN,
    output logic             INTERNAL_RESET_SIGNAL,
    output logic [15:0]      RESET_VECTOR,
    output logic             IRQ
);

    scr_state_type          state_q;
    scr_state_type          state_d;
    logic [SYS_CNT_W-1:0]   sys_cnt_q;
    logic [1:0]             div_q;
    logic                   osc_run_q;
    logic [OPT_W-1:0]       option_q;
    logic [EV_W-1:0]        status_q;
    logic [EV_W-1:0]        mask_q;
    logic [RC_W-1:0]        cause_q;
    logic [4:0]             req_raw;
    logic [4:0]             req_s;
    logic                   regs_rst;
    logic                   int_reset;
    logic                   pin_clk_sel;
    logic [SYS_CNT_W-1:0]   stop_last;
    logic [EV_W-1:0]        ev_set;
    logic                   aw_have_q;
    logic                   w_have_q;
    logic [4:0]             aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   aw_fire;
    logic                   w_fire;
    logic                   ar_fire;
    logic                   wr_go;
    logic                   rd_status_clr;
    logic                   rd_cause_clr;
    scr_src_type            src;

    function automatic logic reg_known(input logic [4:0] a);
        reg_known = (a == OFS_OPTION) || (a == OFS_STATUS) || (a == OFS_MASK)
                    || (a == OFS_CAUSE) || (a == OFS_STATE);
    endfunction : reg_known

    function automatic logic [31:0] reg_read(input logic [4:0] a);
        reg_read = 32'h0000_0000;
        unique case (a)
            OFS_OPTION: reg_read[OPT_W-1:0] = option_q;
            OFS_STATUS: reg_read[EV_W-1:0]  = status_q;
            OFS_MASK:   reg_read[EV_W-1:0]  = mask_q;
            OFS_CAUSE:  reg_read[RC_W-1:0]  = cause_q;
            OFS_STATE:  reg_read = {12'h000, sys_cnt_q, 3'h0, osc_run_q, state_q};
            default:    reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    // Reset requests: pin, watchdog, low voltage, illegal opcode, illegal address
    assign req_raw = {ILLEGAL_ADDRESS, ILLEGAL_OPCODE, LOW_VOLTAGE_INHIBIT,
                      WATCHDOG_RESET, ~RESET_PIN_N};

    scr_sync #(
        .W (5)
    ) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (req_raw),
        .q   (req_s)
    );

    assign int_reset = |req_s[4:1];
    assign regs_rst  = RST || INTERNAL_RESET_SIGNAL;
    assign src       = scr_src_type'({option_q[OPT_SRC_HI], option_q[OPT_SRC_LO]});
    assign pin_clk_sel = ((src == SRC_INTERNAL) || (src == SRC_RC))
                         && option_q[OPT_PIN_CLK];
    assign stop_last = option_q[OPT_SHORT_SD] ? SYS_CNT_W'(STOP_SHORT - 1)
                                              : SYS_CNT_W'(STOP_LONG - 1);

    // Internal reset and vector
    always_ff @(posedge CLK) begin
        if (RST) begin
            INTERNAL_RESET_SIGNAL <= 1'b1;
            RESET_VECTOR          <= VECTOR_USER;
        end else begin
            INTERNAL_RESET_SIGNAL <= |req_s;
            RESET_VECTOR          <= MONITOR_MODE ? VECTOR_MONITOR : VECTOR_USER;
        end
    end

    // Power mode sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_POR_WAIT: begin
                if (sys_cnt_q == SYS_CNT_W'(POR_CYCLES - 1)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (STOP_REQ) begin
                    state_d = ST_STOP;
                end else if (WAIT_REQ) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (WAKE_EVENT || INTERNAL_RESET_SIGNAL) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (WAKE_EVENT || INTERNAL_RESET_SIGNAL) begin
                    state_d = ST_STOP_DELAY;
                end
            end
            ST_STOP_DELAY: begin
                if (sys_cnt_q == stop_last) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_POR_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // System counter runs on the quad-rate clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            sys_cnt_q <= '0;
        end else if (int_reset) begin
            sys_cnt_q <= '0;
        end else if (state_q == ST_STOP) begin
            sys_cnt_q <= '0;
        end else begin
            sys_cnt_q <= sys_cnt_q + SYS_CNT_W'(1);
        end
    end

    // Oscillator and derived clock enables; break state has no effect
    always_ff @(posedge CLK) begin
        if (RST) begin
            osc_run_q <= 1'b1;
            div_q     <= 2'h0;
        end else begin
            osc_run_q <= (state_d != ST_STOP);
            div_q     <= osc_run_q ? div_q + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            OSC_RUNNING          <= 1'b0;
            CLOCK_SOURCE_ENABLE  <= 4'h0;
            DOUBLE_RATE_CLOCK_EN <= 1'b0;
            BUS_CLOCK_EN         <= 1'b0;
            CPU_CLOCK_EN         <= 1'b0;
            PERIPH_CLOCK_EN      <= 1'b0;
        end else begin
            OSC_RUNNING          <= osc_run_q;
            CLOCK_SOURCE_ENABLE  <= osc_run_q ? 4'h1 << src : 4'h0;
            DOUBLE_RATE_CLOCK_EN <= osc_run_q && div_q[0];
            BUS_CLOCK_EN         <= osc_run_q && (div_q == 2'h3)
                                    && (state_q != ST_POR_WAIT);
            CPU_CLOCK_EN         <= osc_run_q && (div_q == 2'h3)
                                    && (state_q == ST_RUN)
                                    && !INTERNAL_RESET_SIGNAL;
            PERIPH_CLOCK_EN      <= osc_run_q && (div_q == 2'h3)
                                    && ((state_q == ST_RUN) || (state_q == ST_WAIT))
                                    && !INTERNAL_RESET_SIGNAL;
        end
    end

    // Shared oscillator pin
    always_ff @(posedge CLK) begin
        if (RST) begin
            SECOND_OSCILLATOR_PIN_OUT    <= 1'b0;
            SECOND_OSCILLATOR_PIN_OE     <= 1'b0;
            PORT_A_LINE_FOUR_IN          <= 1'b0;
            PORT_A_LINE_FOUR_FEATURES_EN <= 1'b1;
        end else if (pin_clk_sel) begin
            SECOND_OSCILLATOR_PIN_OUT    <= osc_run_q && !SECOND_OSCILLATOR_PIN_OUT;
            SECOND_OSCILLATOR_PIN_OE     <= 1'b1;
            PORT_A_LINE_FOUR_IN          <= 1'b0;
            PORT_A_LINE_FOUR_FEATURES_EN <= 1'b0;
        end else begin
            SECOND_OSCILLATOR_PIN_OUT    <= PORT_A_LINE_FOUR_OUT;
            SECOND_OSCILLATOR_PIN_OE     <= PORT_A_LINE_FOUR_OE;
            PORT_A_LINE_FOUR_IN          <= SECOND_OSCILLATOR_PIN_IN;
            PORT_A_LINE_FOUR_FEATURES_EN <= 1'b1;
        end
    end

    // AXI4-Lite write channel
    assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_fire  = S_AXI_WVALID && S_AXI_WREADY;
    assign wr_go   = aw_have_q && w_have_q && !S_AXI_BVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 5'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (w_fire) begin
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            aw_have_q     <= wr_go ? 1'b0 : (aw_have_q || aw_fire);
            w_have_q      <= wr_go ? 1'b0 : (w_have_q || w_fire);
            S_AXI_AWREADY <= wr_go || !(aw_have_q || aw_fire);
            S_AXI_WREADY  <= wr_go || !(w_have_q || w_fire);
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= reg_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    assign ar_fire       = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_status_clr = ar_fire && (S_AXI_ARADDR == OFS_STATUS);
    assign rd_cause_clr  = ar_fire && (S_AXI_ARADDR == OFS_CAUSE);

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (ar_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= reg_read(S_AXI_ARADDR);
            S_AXI_RRESP   <= reg_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID) begin
            S_AXI_RVALID  <= !S_AXI_RREADY;
            S_AXI_ARREADY <= S_AXI_RREADY;
        end else begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Option and mask registers
    always_ff @(posedge CLK) begin
        if (regs_rst) begin
            option_q <= OPTION_RESET;
            mask_q   <= EV_RESET;
        end else if (wr_go && w_strb_q[0]) begin
            if (aw_addr_q == OFS_OPTION) begin
                option_q <= w_data_q[OPT_W-1:0];
            end
            if (aw_addr_q == OFS_MASK) begin
                mask_q <= w_data_q[EV_W-1:0];
            end
        end
    end

    // Sticky events, cleared by read; a new event wins over the clear
    assign ev_set[EV_POR_DONE]  = (state_q == ST_POR_WAIT) && (state_d == ST_RUN);
    assign ev_set[EV_STOP_DONE] = (state_q == ST_STOP_DELAY) && (state_d == ST_RUN);
    assign ev_set[EV_WAIT_IN]   = (state_q == ST_RUN) && (state_d == ST_WAIT);

    always_ff @(posedge CLK) begin
        if (regs_rst) begin
            status_q <= EV_RESET;
            IRQ      <= 1'b0;
        end else begin
            status_q <= (status_q & {EV_W{!rd_status_clr}}) | ev_set;
            IRQ      <= |(status_q & mask_q);
        end
    end

    // Reset cause survives internal resets; only power-on or a read of it clears it
    always_ff @(posedge CLK) begin
        if (RST) begin
            cause_q <= 6'h01;
        end else begin
            cause_q <= (cause_q & {RC_W{!rd_cause_clr}}) | {req_s, 1'b0};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    break_osc_run_a: assert property (
        (BREAK_STATE && state_q == ST_RUN && $past(state_q) == ST_RUN) |-> osc_run_q)
        else $error("oscillator stopped during break");

    pin_clock_out_a: assert property (
        $past(pin_clk_sel) |-> SECOND_OSCILLATOR_PIN_OE && !PORT_A_LINE_FOUR_FEATURES_EN)
        else $error("pin not driving clock");

    bus_divide_a: assert property (
        BUS_CLOCK_EN |=> !BUS_CLOCK_EN [*3])
        else $error("bus clock faster than quarter rate");

    por_hold_a: assert property (
        (state_q == ST_POR_WAIT) |=> !CPU_CLOCK_EN && !PERIPH_CLOCK_EN && !BUS_CLOCK_EN)
        else $error("clocks active during power-on timeout");

    por_length_a: assert property (
        (state_q == ST_POR_WAIT && state_d == ST_RUN)
        |-> sys_cnt_q == SYS_CNT_W'(POR_CYCLES - 1))
        else $error("power-on timeout length wrong");

    stop_delay_a: assert property (
        (state_q == ST_STOP_DELAY && state_d == ST_RUN) |-> sys_cnt_q == stop_last)
        else $error("stop delay length wrong");

    wait_cpu_off_a: assert property (
        (state_q == ST_WAIT && osc_run_q && div_q == 2'h3 && !INTERNAL_RESET_SIGNAL)
        |=> PERIPH_CLOCK_EN && !CPU_CLOCK_EN)
        else $error("wait mode clock gating wrong");

    internal_reset_signal_merge_a: assert property (
        (|req_s) |=> INTERNAL_RESET_SIGNAL)
        else $error("reset request lost");

    syscnt_keep_a: assert property (
        (req_s == 5'h01 && state_q == ST_RUN) |=> sys_cnt_q == $past(sys_cnt_q) + 13'h1)
        else $error("pin reset disturbed system counter");

    cause_bit_a: assert property (
        req_s[1] |=> cause_q[RC_WDOG])
        else $error("watchdog cause bit not set");

    stop_osc_off_a: assert property (
        (state_q == ST_STOP && $past(state_q) == ST_STOP) |-> !osc_run_q ##1 !OSC_RUNNING)
        else $error("oscillator running in stop");

    wait_osc_on_a: assert property (
        (state_q == ST_WAIT) |=> OSC_RUNNING)
        else $error("oscillator stopped in wait");

    cover_por_done: cover property (ev_set[EV_POR_DONE]);
    cover_stop_exit: cover property (ev_set[EV_STOP_DONE]);
    cover_wait_wake: cover property (state_q == ST_WAIT ##1 state_q == ST_RUN);
    cover_irq: cover property ($rose(IRQ));

endmodule : scr_top

`default_nettype wire

/* File: verif/scr_clock_user.sv */
`timescale 1ns/1ns
`default_nettype none

module scr_clock_user (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cpu_en,
    input  wire logic        per_en,
    input  wire logic        bus_en,
    output logic      [15:0] cpu_cnt,
    output logic      [15:0] per_cnt,
    output logic      [7:0]  bus_gap
);
    logic [7:0] gap_q;

    // Counts the clock pulses that the CPU and the peripherals receive
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_cnt <= 16'h0000;
            per_cnt <= 16'h0000;
        end else begin
            cpu_cnt <= cpu_cnt + 16'(cpu_en);
            per_cnt <= per_cnt + 16'(per_en);
        end
    end

    // Spacing of the last two bus clock pulses
    always_ff @(posedge clk) begin
        if (rst || bus_en) begin
            gap_q <= 8'h01;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (bus_en) begin
            bus_gap <= gap_q;
        end
    end
endmodule : scr_clock_user

`default_nettype wire

/* File: verif/system_clock_and_reset_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module system_clock_and_reset_control_bench import scr_pkg::*;;
    localparam int PC = 64;
    localparam int SL = 40;
    localparam int SS = 8;
    logic        CLK = 1'b0, RST = 1'b1;
    logic [4:0]  AWA = 5'h00, ARA = 5'h00;
    logic [31:0] WD = 32'h0;
    logic        AWV = 1'b0, WV = 1'b0, BR = 1'b0, ARV = 1'b0, RR = 1'b0;
    logic        AWR, WR, BV, ARR, RV, IRQ, OE, FEN, OSC, CPU, PER, BUS, IRS;
    logic [1:0]  BRESP, RRESP, r;
    logic [31:0] RD, d, c0;
    logic [3:0]  CSE;
    logic [15:0] VEC, cc, pc;
    logic [7:0]  gap;
    logic        PO, PAI, DRC, prev;
    logic        STP = 1'b0, WTQ = 1'b0, WAKE = 1'b0, BRK = 1'b0, MON = 1'b0, PIN_N = 1'b1;
    logic [3:0]  SRC = 4'h0;
    logic        PIN_IN = 1'b1;
    int          checks = 0, fails = 0, n, cyc = 0;
    int          bitpos [5] = '{RC_PIN, RC_WDOG, RC_LVI, RC_ILLOP, RC_ILLAD};

    scr_top #(.POR_CYCLES(PC), .STOP_LONG(SL), .STOP_SHORT(SS)) u_scr_top (
        .CLK(CLK), .RST(RST), .S_AXI_AWADDR(AWA), .S_AXI_AWVALID(AWV), .S_AXI_AWREADY(AWR),
        .S_AXI_WDATA(WD), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(WV), .S_AXI_WREADY(WR),
        .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BV), .S_AXI_BREADY(BR), .S_AXI_ARADDR(ARA),
        .S_AXI_ARVALID(ARV), .S_AXI_ARREADY(ARR), .S_AXI_RDATA(RD), .S_AXI_RRESP(RRESP),
        .S_AXI_RVALID(RV), .S_AXI_RREADY(RR), .STOP_REQ(STP), .WAIT_REQ(WTQ),
        .WAKE_EVENT(WAKE), .BREAK_STATE(BRK), .MONITOR_MODE(MON), .RESET_PIN_N(PIN_N),
        .WATCHDOG_RESET(SRC[0]), .LOW_VOLTAGE_INHIBIT(SRC[1]), .ILLEGAL_OPCODE(SRC[2]),
        .ILLEGAL_ADDRESS(SRC[3]), .PORT_A_LINE_FOUR_OUT(1'b0), .PORT_A_LINE_FOUR_OE(1'b0),
        .SECOND_OSCILLATOR_PIN_IN(PIN_IN), .SECOND_OSCILLATOR_PIN_OUT(PO),
        .SECOND_OSCILLATOR_PIN_OE(OE), .PORT_A_LINE_FOUR_IN(PAI),
        .PORT_A_LINE_FOUR_FEATURES_EN(FEN), .CLOCK_SOURCE_ENABLE(CSE), .OSC_RUNNING(OSC),
        .DOUBLE_RATE_CLOCK_EN(DRC), .BUS_CLOCK_EN(BUS), .CPU_CLOCK_EN(CPU),
        .PERIPH_CLOCK_EN(PER), .INTERNAL_RESET_SIGNAL(IRS), .RESET_VECTOR(VEC), .IRQ(IRQ)
    );

    scr_clock_user u_scr_clock_user (
        .clk(CLK), .rst(RST), .cpu_en(CPU), .per_en(PER), .bus_en(BUS),
        .cpu_cnt(cc), .per_cnt(pc), .bus_gap(gap)
    );

    initial begin
        forever #5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cyc <= RST ? 0 : cyc + 1;
    end

    task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : cmp

    task wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge CLK);
        AWA <= a;
        WD <= v;
        AWV <= 1'b1;
        WV <= 1'b1;
        BR <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWR) AWV <= 1'b0;
            if (WR) WV <= 1'b0;
        end while (!BV);
        r = BRESP;
        BR <= 1'b0;
    endtask : wr

    task rd(input logic [4:0] a);
        @(posedge CLK);
        ARA <= a;
        ARV <= 1'b1;
        RR <= 1'b1;
        do begin
            @(posedge CLK);
            if (ARR) ARV <= 1'b0;
        end while (!RV);
        d = RD;
        r = RRESP;
        RR <= 1'b0;
    endtask : rd

    task wait_cpu(input int lim);
        n = 0;
        while (CPU !== 1'b1 && n < lim) begin
            @(posedge CLK);
            n++;
        end
    endtask : wait_cpu

    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        rd(OFS_STATE);
        cmp(d[2:0], ST_POR_WAIT, "por wait state");
        rd(OFS_CAUSE);
        cmp(d, 32'h1, "power-on cause");
        rd(OFS_CAUSE);
        cmp(d, 32'h0, "cause cleared by read");
        rd(5'h14);
        cmp(r, RESP_SLVERR, "unmapped read response");
        cmp(d, 32'h0, "unmapped read data");
        wr(5'h14, 32'hF);
        cmp(r, RESP_SLVERR, "unmapped write response");
        wait_cpu(200);
        cmp(cyc >= PC && cyc <= PC + 8, 1'b1, "first cpu clock after timeout");
        repeat (10) @(posedge CLK);
        cmp(gap, 8'h04, "bus clock spacing");
        wr(OFS_MASK, 32'h1);
        cmp(r, RESP_OKAY, "mask write response");
        repeat (2) @(posedge CLK);
        cmp(IRQ, 1'b1, "irq unmasked");
        rd(OFS_STATUS);
        cmp(d, 32'h1, "timeout status");
        repeat (2) @(posedge CLK);
        cmp(IRQ, 1'b0, "irq after read clear");
        for (int s = 0; s < 4; s++) begin
            wr(OFS_OPTION, 32'(4 + s));
            repeat (3) @(posedge CLK);
            cmp(CSE, 4'h1 << s, "source enable");
            cmp(OE, s[0] == 1'b0, "pin clock drive");
            cmp(FEN, s[0], "pin general io");
            prev = PO;
            @(posedge CLK);
            cmp(PO, s[0] ? prev : !prev, "pin clock toggle");
        end
        wr(OFS_OPTION, 32'h8);
        repeat (3) @(posedge CLK);
        cmp({OE, FEN, PAI}, 3'b011, "pin clock off");
        BRK <= 1'b1;
        WTQ <= 1'b1;
        @(posedge CLK);
        WTQ <= 1'b0;
        rd(OFS_STATE);
        cmp(d[2:0], ST_WAIT, "wait state");
        c0 = {cc, pc};
        repeat (20) @(posedge CLK);
        cmp(cc, c0[31:16], "cpu clock held in wait");
        cmp(pc > c0[15:0], 1'b1, "peripheral clock in wait");
        cmp(OSC, 1'b1, "oscillator in wait and break");
        prev = DRC;
        @(posedge CLK);
        cmp(DRC, !prev, "double rate clock in wait and break");
        WAKE <= 1'b1;
        @(posedge CLK);
        WAKE <= 1'b0;
        BRK <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            wr(OFS_OPTION, k ? 32'h0 : 32'h8);
            STP <= 1'b1;
            @(posedge CLK);
            STP <= 1'b0;
            repeat (4) @(posedge CLK);
            cmp({OSC, CSE}, 5'h00, "oscillator off in stop");
            WAKE <= 1'b1;
            @(posedge CLK);
            WAKE <= 1'b0;
            wait_cpu(100);
            cmp(n >= (k ? SL : SS) && n <= (k ? SL : SS) + 8, 1'b1, "stop delay");
        end
        for (int i = 0; i < 5; i++) begin
            wr(OFS_OPTION, 32'h3);
            repeat (100) @(posedge CLK);
            rd(OFS_STATE);
            c0 = d;
            MON <= (i == 1);
            if (i == 0) PIN_N <= 1'b0;
            else SRC <= 4'h1 << (i - 1);
            @(posedge CLK);
            n = 0;
            while (IRS !== 1'b1 && n < 20) begin
                @(posedge CLK);
                n++;
            end
            cmp(n >= 2 && n <= 4, 1'b1, "internal reset delay");
            PIN_N <= 1'b1;
            SRC <= 4'h0;
            repeat (8) @(posedge CLK);
            cmp(VEC, i == 1 ? VECTOR_MONITOR : VECTOR_USER, "reset vector");
            rd(OFS_CAUSE);
            cmp(d, 32'h1 << bitpos[i], "reset cause");
            rd(OFS_OPTION);
            cmp(d, 32'h0, "option default");
            rd(OFS_STATE);
            cmp(i == 0 ? d[19:7] > c0[19:7] : d[19:7] < c0[19:7], 1'b1, "system counter");
        end
        give_verdict();
    end
endmodule : system_clock_and_reset_control_bench

`default_nettype wire
